// [rtl/rhps_pkg.sv]
package rhps_pkg;
  localparam int RHPS_NPORTS = 4;

  // byte offsets of the register words
  localparam logic [7:0] RHPS_OFF_PORT0 = 8'h00;
  localparam logic [7:0] RHPS_OFF_PORT1 = 8'h04;
  localparam logic [7:0] RHPS_OFF_PORT2 = 8'h08;
  localparam logic [7:0] RHPS_OFF_PORT3 = 8'h0c;
  localparam logic [7:0] RHPS_OFF_IRQ_STAT = 8'h10;
  localparam logic [7:0] RHPS_OFF_IRQ_CLR = 8'h14;
  localparam logic [7:0] RHPS_OFF_IRQ_EN = 8'h18;
  localparam logic [7:0] RHPS_OFF_CTRL = 8'h1c;
  localparam logic [7:0] RHPS_OFF_STEP = 8'h04;

  // port word bit positions
  localparam int RHPS_BIT_ATTACH = 0;
  localparam int RHPS_BIT_ENABLE = 1;
  localparam int RHPS_BIT_SUSPEND = 2;
  localparam int RHPS_BIT_RESUME = 3;
  localparam int RHPS_BIT_CONN_CHG = 16;
  localparam int RHPS_BIT_EN_CHG = 17;
  localparam int RHPS_BIT_SUSP_CHG = 18;

  // resume interval in core_clk cycles
  localparam logic [7:0] RHPS_RESUME_CYCLES = 8'h14;
  localparam logic [7:0] RHPS_TMR_ONE = 8'h01;
  localparam logic [7:0] RHPS_TMR_IDLE = 8'h00;

  localparam logic [31:0] RHPS_ZERO32 = 32'h0000_0000;

  // interrupt status bit groups (4 ports each)
  localparam int RHPS_IRQ_CONN = 0;
  localparam int RHPS_IRQ_EN = 4;
  localparam int RHPS_IRQ_SUSP = 8;
  localparam int RHPS_IRQ_WAKE = 12;
  localparam int RHPS_IRQ_W = 16;

  typedef struct packed {
    logic attach_raw;
    logic overcurrent;
    logic power_off;
    logic bus_error;
    logic reset_done;
    logic upstream_resume;
  } rhps_port_in_t;

  typedef struct packed {
    logic sel;
    logic write;
    logic [7:0] addr;
  } rhps_ahb_req_t;
endpackage

// [rtl/rhps_port_status.sv]
// Operation
// - bit 2 reads suspended or resuming
// - suspend clears when resume interval completes
// - suspend clears on reset done, controller resume
// - upstream resume while suspended forwarded to controller
// - write 1 bit 2 suspends if attached
// - suspend on detached port sets connect change
// - bit 1 reads port enabled
// - hardware disable sets enable change flag
// - enable never sets while detached
// - reset or suspend completion sets enable
// - write 1 bit 1 enables if attached
// - enable on detached port sets connect change
// - bit 0 reports live attachment
// - write 1 bit 0 disables port
// - disable write leaves connect bit untouched
// - nonremovable port reads attached always
// - write 1 bit 3 resumes if suspended
//
// The AHB-Lite slave port and the register offsets were left to the implementer.
module rhps_port_status
  import rhps_pkg::*;
(
  // clock, reset, enable
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // downstream ports
  input wire rhps_port_in_t [RHPS_NPORTS-1:0] port_in,
  input wire logic [RHPS_NPORTS-1:0] removable_device_mask,
  input wire logic controller_resume_state,
  // forwarded resume and interrupt
  output logic [RHPS_NPORTS-1:0] resume_to_controller,
  output logic irq
);

  typedef enum logic [1:0] {RHPS_IDLE, RHPS_SUSP, RHPS_RESUMING} rhps_pst_t;

  function automatic logic [7:0] port_offset(input int idx);
    port_offset = 8'(RHPS_OFF_PORT0 + RHPS_OFF_STEP * idx);
  endfunction

  // mask bit clear means the device is nonremovable
  function automatic logic attached(input logic raw, input logic fixed);
    attached = raw | fixed;
  endfunction

  // bus address phase capture
  rhps_ahb_req_t req_q, req_d;
  logic [31:0] hrdata_q, hrdata_d;

  rhps_pst_t st_q [RHPS_NPORTS];
  rhps_pst_t st_d [RHPS_NPORTS];
  logic [7:0] tmr_q [RHPS_NPORTS];
  logic [7:0] tmr_d [RHPS_NPORTS];
  logic [RHPS_NPORTS-1:0] en_q, en_d;
  logic [RHPS_NPORTS-1:0] conn_chg_q, conn_chg_d;
  logic [RHPS_NPORTS-1:0] en_chg_q, en_chg_d;
  logic [RHPS_NPORTS-1:0] susp_chg_q, susp_chg_d;
  logic [RHPS_NPORTS-1:0] attach_q, attach_d;
  logic [RHPS_NPORTS-1:0] wake_q, wake_d;
  logic [RHPS_IRQ_W-1:0] ist_q, ist_d, ien_q, ien_d;
  logic irq_q, irq_d;
  logic [RHPS_IRQ_W-1:0] ev;
  logic [RHPS_NPORTS-1:0] susp_vis;

  logic wr_act;
  logic [31:0] wd;

  always_comb begin
    req_d = req_q;
    if (hready) begin
      req_d.sel = hsel & htrans[1];
      req_d.write = hwrite;
      req_d.addr = haddr[7:0];
    end
  end

  assign wr_act = req_q.sel & req_q.write;
  assign wd = hwdata;

  always_comb begin
    ev = '0;
    for (int p = 0; p < RHPS_NPORTS; p++) begin
      logic att;
      logic pwr;
      logic hit;
      logic hw_off;
      logic cev;
      att = attached(port_in[p].attach_raw, ~removable_device_mask[p]);
      hit = wr_act && (req_q.addr == port_offset(p));
      hw_off = port_in[p].overcurrent | port_in[p].power_off | port_in[p].bus_error;
      pwr = 1'b0;
      cev = 1'b0;
      st_d[p] = st_q[p];
      tmr_d[p] = tmr_q[p];
      en_d[p] = en_q[p];
      conn_chg_d[p] = conn_chg_q[p];
      en_chg_d[p] = en_chg_q[p];
      susp_chg_d[p] = susp_chg_q[p];
      wake_d[p] = st_q[p] == RHPS_SUSP && port_in[p].upstream_resume;
      attach_d[p] = att;
      // software clears change flags with a 1; a new event below still wins
      if (hit && wd[RHPS_BIT_CONN_CHG]) conn_chg_d[p] = 1'b0;
      if (hit && wd[RHPS_BIT_EN_CHG]) en_chg_d[p] = 1'b0;
      if (hit && wd[RHPS_BIT_SUSP_CHG]) susp_chg_d[p] = 1'b0;
      if (hit && wd[RHPS_BIT_ATTACH]) en_d[p] = 1'b0;
      if (hit && wd[RHPS_BIT_ENABLE]) begin
        if (att) en_d[p] = 1'b1;
        else begin
          conn_chg_d[p] = 1'b1;
          cev = 1'b1;
        end
      end
      if (hit && wd[RHPS_BIT_SUSPEND]) begin
        if (att && st_q[p] == RHPS_IDLE) st_d[p] = RHPS_SUSP;
        else if (!att) begin
          conn_chg_d[p] = 1'b1;
          cev = 1'b1;
        end
      end
      if (st_q[p] == RHPS_SUSP && ((hit && wd[RHPS_BIT_RESUME]) ||
          port_in[p].upstream_resume)) begin
        st_d[p] = RHPS_RESUMING;
        tmr_d[p] = RHPS_RESUME_CYCLES;
      end
      if (st_q[p] == RHPS_RESUMING) begin
        if (tmr_q[p] == RHPS_TMR_ONE) begin
          st_d[p] = RHPS_IDLE;
          susp_chg_d[p] = 1'b1;
          if (att) en_d[p] = 1'b1;
          ev[RHPS_IRQ_SUSP + p] = 1'b1;
        end
        tmr_d[p] = tmr_q[p] - RHPS_TMR_ONE;
      end
      if (port_in[p].reset_done) begin
        st_d[p] = RHPS_IDLE;
        if (att) en_d[p] = 1'b1;
      end
      if (controller_resume_state) st_d[p] = RHPS_IDLE;
      if (en_q[p] && (hw_off || !att)) begin
        en_d[p] = 1'b0;
        pwr = 1'b1;
      end
      if (pwr) en_chg_d[p] = 1'b1;
      if (!att) en_d[p] = 1'b0;
      // a refused request counts even while an older change is still pending
      ev[RHPS_IRQ_CONN + p] = cev;
      ev[RHPS_IRQ_EN + p] = pwr;
      ev[RHPS_IRQ_WAKE + p] = wake_d[p] & ~wake_q[p];
    end
  end

  always_comb begin
    ien_d = ien_q;
    ist_d = ist_q;
    if (wr_act && req_q.addr == RHPS_OFF_IRQ_EN) ien_d = wd[RHPS_IRQ_W-1:0];
    if (wr_act && req_q.addr == RHPS_OFF_IRQ_CLR) ist_d = ist_d & ~wd[RHPS_IRQ_W-1:0];
    ist_d = ist_d | ev;
    irq_d = |(ist_d & ien_d);
  end

  // suspended or still resuming, as software sees it
  always_comb begin
    for (int p = 0; p < RHPS_NPORTS; p++) begin
      susp_vis[p] = st_q[p] != RHPS_IDLE;
    end
  end

  // read data is captured in the address phase so it stands through the data phase;
  // a write landing in that same data phase is not yet visible to the read
  always_comb begin
    hrdata_d = RHPS_ZERO32;
    if (hready && hsel && htrans[1] && !hwrite) begin
      for (int p = 0; p < RHPS_NPORTS; p++) begin
        if (haddr[7:0] == port_offset(p)) begin
          hrdata_d[RHPS_BIT_ATTACH] = attach_q[p];
          hrdata_d[RHPS_BIT_ENABLE] = en_q[p];
          hrdata_d[RHPS_BIT_SUSPEND] = susp_vis[p];
          hrdata_d[RHPS_BIT_CONN_CHG] = conn_chg_q[p];
          hrdata_d[RHPS_BIT_EN_CHG] = en_chg_q[p];
          hrdata_d[RHPS_BIT_SUSP_CHG] = susp_chg_q[p];
        end
      end
      if (haddr[7:0] == RHPS_OFF_IRQ_STAT) hrdata_d[RHPS_IRQ_W-1:0] = ist_q;
      if (haddr[7:0] == RHPS_OFF_IRQ_EN) hrdata_d[RHPS_IRQ_W-1:0] = ien_q;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      req_q <= '0;
      hrdata_q <= RHPS_ZERO32;
      en_q <= '0;
      conn_chg_q <= '0;
      en_chg_q <= '0;
      susp_chg_q <= '0;
      attach_q <= '0;
      wake_q <= '0;
      ist_q <= '0;
      ien_q <= '0;
      irq_q <= 1'b0;
      for (int p = 0; p < RHPS_NPORTS; p++) begin
        st_q[p] <= RHPS_IDLE;
        tmr_q[p] <= RHPS_TMR_IDLE;
      end
    end else if (clk_en) begin
      req_q <= req_d;
      hrdata_q <= hrdata_d;
      en_q <= en_d;
      conn_chg_q <= conn_chg_d;
      en_chg_q <= en_chg_d;
      susp_chg_q <= susp_chg_d;
      attach_q <= attach_d;
      wake_q <= wake_d;
      ist_q <= ist_d;
      ien_q <= ien_d;
      irq_q <= irq_d;
      for (int p = 0; p < RHPS_NPORTS; p++) begin
        st_q[p] <= st_d[p];
        tmr_q[p] <= tmr_d[p];
      end
    end
  end

  assign hrdata = hrdata_q;
  // zero wait states; the slave never stretches a transfer
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign resume_to_controller = wake_q;
  assign irq = irq_q;

  AST_EN_NEEDS_ATTACH: assert property (@(posedge core_clk) disable iff (sys_rst)
    ((en_q & ~attach_q) == '0))
    else $error("port enabled while detached");

  AST_SUSP_SETS: assert property (@(posedge core_clk) disable iff (sys_rst)
    (clk_en && wr_act && req_q.addr == RHPS_OFF_PORT1 && wd[RHPS_BIT_SUSPEND] &&
     attach_d[1] && st_q[1] == RHPS_IDLE && !controller_resume_state &&
     !port_in[1].reset_done) |=> st_q[1] == RHPS_SUSP)
    else $error("suspend write ignored");

  AST_SUSP_DETACHED: assert property (@(posedge core_clk) disable iff (sys_rst)
    (clk_en && wr_act && req_q.addr == RHPS_OFF_PORT0 && wd[RHPS_BIT_SUSPEND] &&
     !attach_d[0]) |=> conn_chg_q[0] && st_q[0] != RHPS_SUSP)
    else $error("suspend of detached port");

  AST_EN_DETACHED: assert property (@(posedge core_clk) disable iff (sys_rst)
    (clk_en && wr_act && req_q.addr == RHPS_OFF_PORT0 && wd[RHPS_BIT_ENABLE] &&
     !attach_d[0]) |=> conn_chg_q[0] && !en_q[0])
    else $error("enable of detached port");

  AST_DISABLE: assert property (@(posedge core_clk) disable iff (sys_rst)
    (clk_en && wr_act && req_q.addr == RHPS_OFF_PORT2 && wd[RHPS_BIT_ATTACH] &&
     !wd[RHPS_BIT_ENABLE] && !port_in[2].reset_done && st_q[2] != RHPS_RESUMING)
    |=> !en_q[2])
    else $error("disable write ignored");

  AST_HW_OFF: assert property (@(posedge core_clk) disable iff (sys_rst)
    (clk_en && en_q[0] && port_in[0].overcurrent) |=> !en_q[0] && en_chg_q[0])
    else $error("hardware disable without change flag");

  AST_RESUME_END: assert property (@(posedge core_clk) disable iff (sys_rst)
    (clk_en && st_q[1] == RHPS_RESUMING && tmr_q[1] == RHPS_TMR_ONE)
    |=> st_q[1] == RHPS_IDLE && susp_chg_q[1])
    else $error("resume end missed");

  AST_CTRL_RESUME: assert property (@(posedge core_clk) disable iff (sys_rst)
    (clk_en && controller_resume_state) |=> st_q[3] == RHPS_IDLE)
    else $error("controller resume left port suspended");

  AST_NONREMOVABLE: assert property (@(posedge core_clk) disable iff (sys_rst)
    (clk_en && !removable_device_mask[0]) |=> attach_q[0])
    else $error("nonremovable port reads detached");

  AST_WAKE_FWD: assert property (@(posedge core_clk) disable iff (sys_rst)
    (clk_en && st_q[1] == RHPS_SUSP && port_in[1].upstream_resume)
    |=> resume_to_controller[1])
    else $error("upstream resume not forwarded");

  AST_READ_ATTACH: assert property (@(posedge core_clk) disable iff (sys_rst)
    (clk_en && hready && hsel && htrans[1] && !hwrite && haddr[7:0] == RHPS_OFF_PORT1)
    |=> hrdata[RHPS_BIT_ATTACH] == $past(attach_q[1]))
    else $error("connect bit read wrong");

  AST_READ_ENABLE: assert property (@(posedge core_clk) disable iff (sys_rst)
    (clk_en && hready && hsel && htrans[1] && !hwrite && haddr[7:0] == RHPS_OFF_PORT1)
    |=> hrdata[RHPS_BIT_ENABLE] == $past(en_q[1]))
    else $error("enable bit read wrong");

  AST_READ_SUSPEND: assert property (@(posedge core_clk) disable iff (sys_rst)
    (clk_en && hready && hsel && htrans[1] && !hwrite && haddr[7:0] == RHPS_OFF_PORT1)
    |=> hrdata[RHPS_BIT_SUSPEND] == $past(susp_vis[1]))
    else $error("suspend bit read wrong");

  AST_ZERO_WRITE: assert property (@(posedge core_clk) disable iff (sys_rst)
    (clk_en && wr_act && req_q.addr == RHPS_OFF_PORT1 &&
     wd[RHPS_BIT_RESUME:RHPS_BIT_ATTACH] == 4'h0 && attach_d[1] && st_q[1] == RHPS_IDLE &&
     !controller_resume_state && !port_in[1].reset_done && !port_in[1].overcurrent &&
     !port_in[1].power_off && !port_in[1].bus_error)
    |=> $stable(en_q[1]) && $stable(st_q[1]))
    else $error("write of zero changed the port");

  AST_EN_WRITE: assert property (@(posedge core_clk) disable iff (sys_rst)
    (clk_en && wr_act && req_q.addr == RHPS_OFF_PORT0 && wd[RHPS_BIT_ENABLE] &&
     !wd[RHPS_BIT_ATTACH] && attach_d[0] && !port_in[0].overcurrent &&
     !port_in[0].power_off && !port_in[0].bus_error)
    |=> en_q[0])
    else $error("enable write ignored");

  AST_CONN_CHG_IRQ: assert property (@(posedge core_clk) disable iff (sys_rst)
    (clk_en && wr_act && req_q.addr == RHPS_OFF_PORT0 && wd[RHPS_BIT_ENABLE] &&
     !attach_d[0]) |=> ist_q[RHPS_IRQ_CONN] && conn_chg_q[0])
    else $error("refused enable raised no event");

  AST_RESET_DONE: assert property (@(posedge core_clk) disable iff (sys_rst)
    (clk_en && port_in[2].reset_done && attach_d[2] && !port_in[2].overcurrent &&
     !port_in[2].power_off && !port_in[2].bus_error)
    |=> en_q[2] && st_q[2] == RHPS_IDLE)
    else $error("reset completion left port disabled");

  AST_RESUME_START: assert property (@(posedge core_clk) disable iff (sys_rst)
    (clk_en && wr_act && req_q.addr == RHPS_OFF_PORT1 && wd[RHPS_BIT_RESUME] &&
     st_q[1] == RHPS_SUSP && !controller_resume_state && !port_in[1].reset_done)
    |=> st_q[1] == RHPS_RESUMING && tmr_q[1] == RHPS_RESUME_CYCLES)
    else $error("resume write ignored");

  AST_IDLE_NO_RESUME: assert property (@(posedge core_clk) disable iff (sys_rst)
    (clk_en && st_q[2] == RHPS_IDLE)
    |=> st_q[2] != RHPS_RESUMING)
    else $error("resume started on a port that was not suspended");

  AST_EVENT_STICKY: assert property (@(posedge core_clk) disable iff (sys_rst)
    (clk_en && en_q[0] && port_in[0].overcurrent)
    |=> ist_q[RHPS_IRQ_EN])
    else $error("hardware disable not recorded in status");

  AST_DETACH_OFF: assert property (@(posedge core_clk) disable iff (sys_rst)
    (clk_en && en_q[0] && !attach_d[0])
    |=> !en_q[0] && en_chg_q[0])
    else $error("detach left port enabled");

  AST_DISABLE_KEEPS_ATTACH: assert property (@(posedge core_clk) disable iff (sys_rst)
    (clk_en && wr_act && req_q.addr == RHPS_OFF_PORT2 && wd[RHPS_BIT_ATTACH] &&
     attach_d[2])
    |=> attach_q[2])
    else $error("disable write changed connect bit");

  AST_PORT3_SUSP: assert property (@(posedge core_clk) disable iff (sys_rst)
    (clk_en && wr_act && req_q.addr == RHPS_OFF_PORT3 && wd[RHPS_BIT_SUSPEND] &&
     attach_d[3] && st_q[3] == RHPS_IDLE && !controller_resume_state &&
     !port_in[3].reset_done)
    |=> st_q[3] == RHPS_SUSP)
    else $error("last port does not suspend");

  AST_WAKE_IRQ: assert property (@(posedge core_clk) disable iff (sys_rst)
    (clk_en && st_q[1] == RHPS_SUSP && port_in[1].upstream_resume && !wake_q[1])
    |=> ist_q[RHPS_IRQ_WAKE + 1])
    else $error("upstream wake not recorded in status");

  AST_RESUME_DONE_IRQ: assert property (@(posedge core_clk) disable iff (sys_rst)
    (clk_en && st_q[1] == RHPS_RESUMING && tmr_q[1] == RHPS_TMR_ONE)
    |=> ist_q[RHPS_IRQ_SUSP + 1])
    else $error("resume end not recorded in status");

endmodule

// [verification/rhps_dev_model.sv]
module rhps_dev_model
  import rhps_pkg::*;
(
  // commands from the bench
  input wire logic [3:0] attach,
  input wire logic [3:0] fault,
  input wire logic [1:0] fault_kind,
  input wire logic [3:0] rst_done,
  input wire logic [3:0] wake,
  // towards the port logic
  output rhps_port_in_t [RHPS_NPORTS-1:0] port_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // kind 3 is an unplug: the device simply vanishes from the wire
  always_comb begin
    for (int i = 0; i < RHPS_NPORTS; i++) begin
      port_in[i].attach_raw = attach[i] & ~(fault[i] & (fault_kind == 2'h3));
      port_in[i].overcurrent = fault[i] & (fault_kind == 2'h0);
      port_in[i].power_off = fault[i] & (fault_kind == 2'h1);
      port_in[i].bus_error = fault[i] & (fault_kind == 2'h2);
      port_in[i].reset_done = rst_done[i];
      port_in[i].upstream_resume = wake[i];
    end
  end
endmodule

// [verification/root_hub_port_status_bits_test.sv]
module root_hub_port_status_bits_test;
  import rhps_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] A = 32'h1 << RHPS_BIT_ATTACH;
  localparam logic [31:0] E = 32'h1 << RHPS_BIT_ENABLE;
  localparam logic [31:0] S = 32'h1 << RHPS_BIT_SUSPEND;
  localparam logic [31:0] R = 32'h1 << RHPS_BIT_RESUME;
  localparam logic [31:0] CC = 32'h1 << RHPS_BIT_CONN_CHG;
  localparam logic [31:0] EC = 32'h1 << RHPS_BIT_EN_CHG;
  localparam logic [31:0] SC = 32'h1 << RHPS_BIT_SUSP_CHG;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic [3:0] attach = 4'h0, fault = 4'h0, rst_done = 4'h0, wake = 4'h0, rmask = 4'hf;
  logic [1:0] fault_kind = 2'h0;
  logic ctl_resume = 1'b0;
  logic [3:0] r2c;
  logic irq;
  rhps_port_in_t [RHPS_NPORTS-1:0] port_in;
  int errors = 0;
  int check_count = 0;
  always #20 core_clk = ~core_clk;
  rhps_dev_model dev (.attach(attach), .fault(fault), .fault_kind(fault_kind),
    .rst_done(rst_done), .wake(wake), .port_in(port_in));
  rhps_port_status uut (.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(1'b1), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(),
    .port_in(port_in), .removable_device_mask(rmask), .controller_resume_state(ctl_resume),
    .resume_to_controller(r2c), .irq(irq));
  task automatic conclude();
    if (errors == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  function automatic logic [7:0] pa(input int p);
    return 8'(RHPS_OFF_PORT0 + RHPS_OFF_STEP * p);
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q & m, exp);
  endtask
  initial begin
    cyc(20);
    sys_rst <= 1'b0;
    cyc(1);
    for (int p = 0; p < 4; p++) rdm(pa(p), A | E | S, 32'h0);
    wr(RHPS_OFF_CTRL, 32'hffff_ffff);
    rdm(RHPS_OFF_CTRL, 32'hffff_ffff, 32'h0);
    // requests on an empty port only flag a connect change
    wr(pa(0), E);
    rdm(pa(0), A | E | CC, CC);
    wr(pa(0), CC);
    wr(pa(0), S);
    rdm(pa(0), A | S | CC, CC);
    attach <= 4'hf;
    cyc(2);
    for (int p = 0; p < 4; p++) begin
      wr(pa(p), CC | EC | SC);
      wr(pa(p), E);
      rdm(pa(p), A | E | S, A | E);
      wr(pa(p), 32'h0);
      rdm(pa(p), A | E | S, A | E);
      wr(pa(p), A);
      rdm(pa(p), A | E, A);
    end
    wr(pa(1), E);
    wr(pa(1), S);
    rdm(pa(1), A | E | S, A | E | S);
    wr(pa(1), R);
    rdm(pa(1), S, S);
    cyc(RHPS_RESUME_CYCLES + 4);
    rdm(pa(1), A | E | S | SC, A | E | SC);
    wr(pa(2), S);
    rst_done[2] <= 1'b1;
    cyc(1);
    rst_done[2] <= 1'b0;
    cyc(2);
    rdm(pa(2), A | E | S, A | E);
    wr(pa(3), S);
    ctl_resume <= 1'b1;
    cyc(2);
    ctl_resume <= 1'b0;
    rdm(pa(3), A | S, A);
    wr(pa(1), S);
    wake[1] <= 1'b1;
    cyc(2);
    chk({28'h0, r2c}, 32'h2);
    wake[1] <= 1'b0;
    cyc(RHPS_RESUME_CYCLES + 4);
    // every hardware cause of a disable, interrupt still masked
    wr(RHPS_OFF_IRQ_EN, 32'h0);
    for (int k = 0; k < 4; k++) begin
      wr(pa(0), CC | EC | SC);
      wr(pa(0), E);
      fault_kind <= 2'(k);
      fault[0] <= 1'b1;
      cyc(3);
      fault[0] <= 1'b0;
      cyc(3);
      rdm(pa(0), E | EC, EC);
      chk({31'h0, irq}, 32'h0);
    end
    wr(RHPS_OFF_IRQ_EN, 32'h10);
    cyc(2);
    chk({31'h0, irq}, 32'h1);
    wr(RHPS_OFF_IRQ_CLR, 32'hffff);
    cyc(2);
    chk({31'h0, irq}, 32'h0);
    rdm(RHPS_OFF_IRQ_STAT, 32'h10, 32'h0);
    attach <= 4'h0;
    rmask <= 4'he;
    cyc(3);
    rdm(pa(0), A, A);
    rdm(pa(1), A, 32'h0);
    conclude();
  end
  // the sequence needs about 250 cycles
  initial begin
    cyc(5000);
    errors++;
    conclude();
  end
endmodule
